/* core/ufb_pkg.sv */
// Shared constants for the flow-control and bypass block.
// Assumes a single clock domain and byte-wide FIFO data.
package ufb_pkg;
   localparam int UFB_DATA_W = 8;
   localparam int UFB_DEPTH = 64;
   localparam int UFB_CNT_W = 7;
   localparam int UFB_BUF_DEPTH = 8;
   localparam logic [8:0] UFB_BYPASS_ADDR = 9'h140;
   localparam logic [8:0] UFB_MCR_WR_ADDR = 9'h130;
   localparam int UFB_SCR_BYPASS_BIT = 7;
   localparam int UFB_MCR_ACTS_BIT = 5;
   localparam int UFB_MCR_RTS_BIT = 1;
   localparam int UFB_FCR_ARTS_BIT = 4;
   localparam int UFB_FCR_EXT_BIT = 5;
   localparam logic [6:0] UFB_DEPTH_16 = 7'h10;
   localparam logic [6:0] UFB_DEPTH_64 = 7'h40;
   localparam logic [6:0] UFB_RTS_LVL_16 = 7'h0e;
   localparam logic [6:0] UFB_RTS_LVL_64 = 7'h38;
   localparam logic [6:0] UFB_TRIG_64_0 = 7'h01;
   localparam logic [6:0] UFB_TRIG_64_1 = 7'h10;
   localparam logic [6:0] UFB_TRIG_64_2 = 7'h20;
   localparam logic [6:0] UFB_TRIG_64_3 = 7'h38;
   localparam logic [6:0] UFB_TRIG_16_0 = 7'h01;
   localparam logic [6:0] UFB_TRIG_16_1 = 7'h04;
   localparam logic [6:0] UFB_TRIG_16_2 = 7'h08;
   localparam logic [6:0] UFB_TRIG_16_3 = 7'h0e;
endpackage

/* core/ufb_stream_if.sv */
// Valid/ready stream of W-bit words between the block's own modules.
// Assumes both ends share clk_i.
`timescale 1ns/1ps
interface ufb_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* core/ufb_fifo.sv */
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ufb_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic flush_i,
   ufb_stream_if.snk in_s,
   ufb_stream_if.src out_s,
   output logic [$clog2(DEPTH):0] count_o
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
   logic [AW:0] cnt, next_cnt;
   logic push, pop;

   assign in_s.ready = (cnt != (AW+1)'(DEPTH));
   assign out_s.valid = (cnt != '0);
   assign out_s.data = mem[rd_ptr];
   assign count_o = cnt;
   assign push = in_s.valid && in_s.ready;
   assign pop = out_s.valid && out_s.ready;

   always_comb
   begin
      next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      next_cnt = cnt;
      if (push && !pop)
      begin
         next_cnt = cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         next_cnt = cnt - 1'b1;
      end
      if (flush_i)
      begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_cnt = '0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         cnt <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         cnt <= next_cnt;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (push && !flush_i)
      begin
         mem[wr_ptr] <= in_s.data;
      end
   end
endmodule

/* core/ufb_ctrl.sv */
// Flow control and serial bypass logic around a FIFO UART core.
// Assumes the serial engines, FIFO storage and host register file sit
// outside and exchange plain strobes with this block on clk_i.
// Assumes subsystem strobes last one cycle and the receive FIFO count
// is already settled in the cycle it is presented.
// Function
// - Control bit 7 selects parallel bypass
// - Bypass write at 0x140 pushes receive FIFO
// - Bypass read at 0x140 pops transmit FIFO
// - Bypass masks parity, framing, break interrupts
// - CTS high: finish character, then stop
// - CTS low again: transmission resumes
// - Auto-CTS leaves interrupts unchanged
// - Auto-RTS needs FIFO bit 4, extend low
// - RTS threshold independent of trigger level
// - 16-byte mode: clear RTS at 14
// - Cleared RTS bit drives RTS high
// - 64-byte mode: clear RTS at 56
// - Data-available interrupt still at trigger
// - Interrupts same with or without auto-RTS
// - Bit 5 depth, bit 4 auto-RTS, extend gates
// - 64-byte trigger levels 1/16/32/56
// - Reset clears bypass enable
`timescale 1ns/1ps
module ufb_ctrl
   import ufb_pkg::*;
#(
   parameter int DW = UFB_DATA_W,
   parameter int BUF_DEPTH = UFB_BUF_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic extend_disable_i,
   // Subsystem side.
   input wire logic [8:0] sub_addr_i,
   input wire logic sub_wr_i,
   input wire logic sub_rd_i,
   input wire logic [DW-1:0] sub_wdata_i,
   output logic [DW-1:0] sub_rdata_o,
   output logic sub_rvalid_o,
   input wire logic [7:0] scr_wdata_i,
   input wire logic scr_wr_i,
   output logic bypass_o,
   // Host side.
   input wire logic [7:0] fcr_wdata_i,
   input wire logic fcr_wr_i,
   input wire logic mcr_rts_set_i,
   input wire logic mcr_rts_clr_i,
   output logic auto_cts_o,
   output logic auto_rts_o,
   output logic depth64_o,
   output logic [6:0] trigger_level_o,
   // Serial receiver.
   input wire logic ser_rx_valid_i,
   input wire logic [DW-1:0] ser_rx_data_i,
   input wire logic ser_rx_pe_i,
   input wire logic ser_rx_fe_i,
   input wire logic ser_rx_bi_i,
   output logic ser_rx_ready_o,
   // Receive FIFO write port and its fill level.
   output logic rxf_push_o,
   output logic [DW-1:0] rxf_data_o,
   output logic [2:0] rxf_err_o,
   input wire logic rxf_full_i,
   input wire logic [UFB_CNT_W-1:0] rxf_count_i,
   output logic rx_avail_irq_o,
   output logic rx_err_irq_o,
   // Transmit FIFO read port.
   input wire logic txf_valid_i,
   input wire logic [DW-1:0] txf_data_i,
   output logic txf_pop_o,
   // Serial transmitter.
   input wire logic cts_n_i,
   input wire logic tx_busy_i,
   input wire logic tx_char_done_i,
   output logic tx_start_o,
   output logic [DW-1:0] tx_data_o,
   output logic rts_n_o
);
   // =====================================================================
   // Subsystem address decode
   // =====================================================================
   // Only the two addresses owned by this block are decoded here; the
   // rest of the subsystem map is handled outside.
   logic at_byp_addr;
   logic at_mcr_addr;

   function automatic logic sub_hit(
      input logic [8:0] a,
      input logic [8:0] want
   );
      return a == want;
   endfunction

   assign at_byp_addr = sub_hit(sub_addr_i, UFB_BYPASS_ADDR);
   assign at_mcr_addr = sub_hit(sub_addr_i, UFB_MCR_WR_ADDR);

   // =====================================================================
   // Configuration state
   // =====================================================================
   logic bypass, next_bypass;
   logic acts, next_acts;
   logic [7:0] fifo_control_reg, next_fcr;
   logic rts_bit, next_rts_bit;
   logic ext_ok;
   logic [6:0] rts_level;
   logic rts_hit;

   function automatic logic [6:0] trig_of(input logic [1:0] code, input logic deep);
      logic [6:0] lv;
      lv = UFB_TRIG_16_0;
      unique case (code)
         2'h0: lv = deep ? UFB_TRIG_64_0 : UFB_TRIG_16_0;
         2'h1: lv = deep ? UFB_TRIG_64_1 : UFB_TRIG_16_1;
         2'h2: lv = deep ? UFB_TRIG_64_2 : UFB_TRIG_16_2;
         2'h3: lv = deep ? UFB_TRIG_64_3 : UFB_TRIG_16_3;
      endcase
      return lv;
   endfunction

   assign ext_ok = !extend_disable_i;
   assign depth64_o = fifo_control_reg[UFB_FCR_EXT_BIT] && ext_ok;
   assign auto_rts_o = fifo_control_reg[UFB_FCR_ARTS_BIT] && ext_ok;
   assign trigger_level_o = trig_of(fifo_control_reg[7:6], depth64_o);
   // The stop level is a fixed compare, not the programmed trigger.
   assign rts_level = depth64_o ? UFB_RTS_LVL_64 : UFB_RTS_LVL_16;
   assign rts_hit = auto_rts_o && (rxf_count_i >= rts_level);
   assign bypass_o = bypass;
   assign auto_cts_o = acts;
   assign rts_n_o = !rts_bit;

   always_comb
   begin
      next_bypass = bypass;
      next_acts = acts;
      next_fcr = fifo_control_reg;
      next_rts_bit = rts_bit;
      if (scr_wr_i)
      begin
         next_bypass = scr_wdata_i[UFB_SCR_BYPASS_BIT];
      end
      if (sub_wr_i && at_mcr_addr)
      begin
         next_acts = sub_wdata_i[UFB_MCR_ACTS_BIT];
      end
      if (fcr_wr_i)
      begin
         next_fcr = fcr_wdata_i;
      end
      // Host sets the bit back after draining; no automatic reassert.
      if (mcr_rts_clr_i)
      begin
         next_rts_bit = 1'b0;
      end
      else if (mcr_rts_set_i)
      begin
         next_rts_bit = 1'b1;
      end
      // Hardware clear wins over a host set in the same cycle.
      if (rts_hit)
      begin
         next_rts_bit = 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bypass <= 1'b0;
         acts <= 1'b0;
         fifo_control_reg <= 8'h00;
         rts_bit <= 1'b0;
      end
      else
      begin
         bypass <= next_bypass;
         acts <= next_acts;
         fifo_control_reg <= next_fcr;
         rts_bit <= next_rts_bit;
      end
   end

   // =====================================================================
   // Receive path: serial or parallel source into the receive FIFO
   // =====================================================================
   // The small staging buffer lets a bypass write land even while the
   // receive FIFO is momentarily full; when it fills, the serial source stalls.
   // The subsystem has no ready, so a bypass write into a full staging
   // buffer is lost; software must pace its writes against the fill level.
   ufb_stream_if #(.W(DW + 3)) rx_in ();
   ufb_stream_if #(.W(DW + 3)) rx_out ();
   logic byp_wr;

   assign byp_wr = bypass && sub_wr_i && at_byp_addr;
   assign rx_in.valid = bypass ? byp_wr : ser_rx_valid_i;
   // Parallel bytes carry no line errors, so those interrupts stay quiet.
   assign rx_in.data = bypass ? {3'h0, sub_wdata_i} :
      {ser_rx_bi_i, ser_rx_fe_i, ser_rx_pe_i, ser_rx_data_i};
   assign ser_rx_ready_o = !bypass && rx_in.ready;
   assign rx_out.ready = !rxf_full_i;

   ufb_fifo #(.W(DW + 3), .DEPTH(BUF_DEPTH)) u_rx_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .flush_i(1'b0),
      .in_s(rx_in),
      .out_s(rx_out),
      .count_o()
   );

   logic [DW-1:0] rx_data_q, next_rx_data_q;
   logic [2:0] rx_err_q, next_rx_err_q;
   logic rx_push_q, next_rx_push_q;
   logic err_irq_q, next_err_irq_q;
   logic rx_take;

   assign rx_take = rx_out.valid && rx_out.ready;

   always_comb
   begin
      next_rx_push_q = rx_take;
      next_rx_data_q = rx_out.data[DW-1:0];
      next_rx_err_q = rx_out.data[DW+2:DW];
      next_err_irq_q = next_rx_push_q && (|rx_out.data[DW+2:DW]);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_push_q <= 1'b0;
         rx_data_q <= '0;
         rx_err_q <= 3'h0;
         err_irq_q <= 1'b0;
      end
      else
      begin
         rx_push_q <= next_rx_push_q;
         rx_data_q <= next_rx_data_q;
         rx_err_q <= next_rx_err_q;
         err_irq_q <= next_err_irq_q;
      end
   end

   assign rxf_push_o = rx_push_q;
   assign rxf_data_o = rx_data_q;
   assign rxf_err_o = rx_err_q;
   assign rx_err_irq_o = err_irq_q;
   // Flow control modes do not enter this term.
   assign rx_avail_irq_o = (rxf_count_i >= trigger_level_o);

   // =====================================================================
   // Transmit path: FIFO to serial engine or to subsystem reads
   // =====================================================================
   typedef enum {UFB_TX_IDLE, UFB_TX_SEND} ufb_tx_e;
   ufb_tx_e tx_st, next_tx_st;
   logic tx_go;
   logic byp_rd;
   logic [DW-1:0] rdata_q, next_rdata_q;
   logic rvalid_q, next_rvalid_q;
   logic [DW-1:0] txd_q, next_txd_q;
   logic txs_q, next_txs_q;

   logic tx_idle;
   logic cts_block;

   assign byp_rd = bypass && sub_rd_i && at_byp_addr && txf_valid_i;
   // Auto-CTS only gates the start of a character, so a stop request
   // that arrives mid-character lets that character run to its end.
   assign cts_block = acts && cts_n_i;
   assign tx_idle = (tx_st == UFB_TX_IDLE) && !tx_busy_i;
   assign tx_go = !bypass && tx_idle && txf_valid_i && !cts_block;
   assign txf_pop_o = byp_rd || tx_go;

   always_comb
   begin
      next_tx_st = tx_st;
      next_rdata_q = rdata_q;
      next_rvalid_q = byp_rd;
      next_txd_q = txd_q;
      next_txs_q = tx_go;
      if (byp_rd)
      begin
         next_rdata_q = txf_data_i;
      end
      unique case (tx_st)
         UFB_TX_IDLE:
         begin
            if (tx_go)
            begin
               next_txd_q = txf_data_i;
               next_tx_st = UFB_TX_SEND;
            end
         end
         UFB_TX_SEND:
         begin
            // The current character always completes, whatever CTS does.
            if (tx_char_done_i)
            begin
               next_tx_st = UFB_TX_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_st <= UFB_TX_IDLE;
         rdata_q <= '0;
         rvalid_q <= 1'b0;
         txd_q <= '0;
         txs_q <= 1'b0;
      end
      else
      begin
         tx_st <= next_tx_st;
         rdata_q <= next_rdata_q;
         rvalid_q <= next_rvalid_q;
         txd_q <= next_txd_q;
         txs_q <= next_txs_q;
      end
   end

   assign sub_rdata_o = rdata_q;
   assign sub_rvalid_o = rvalid_q;
   assign tx_data_o = txd_q;
   assign tx_start_o = txs_q;
endmodule

/* bench/ufb_ctrl_properties.sv */
// Concurrent checks on the ports of ufb_ctrl.
// Assumes one clock domain; bound by the statement after the module.
`timescale 1ns/1ps
module ufb_ctrl_checker
   import ufb_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic extend_disable_i,
   input wire logic [8:0] sub_addr_i,
   input wire logic sub_rd_i,
   input wire logic sub_rvalid_o,
   input wire logic [7:0] sub_rdata_o,
   input wire logic bypass_o,
   input wire logic mcr_rts_set_i,
   input wire logic auto_cts_o,
   input wire logic auto_rts_o,
   input wire logic depth64_o,
   input wire logic [6:0] trigger_level_o,
   input wire logic [6:0] rxf_count_i,
   input wire logic rx_avail_irq_o,
   input wire logic txf_valid_i,
   input wire logic [7:0] txf_data_i,
   input wire logic txf_pop_o,
   input wire logic cts_n_i,
   input wire logic tx_start_o,
   input wire logic [7:0] tx_data_o,
   input wire logic rts_n_o
);
   // ====================================
   // Properties
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   AST_RTS_AT_14: assert property (auto_rts_o && !depth64_o && rxf_count_i >= 7'h0e |=> rts_n_o)
      else $error("rts not dropped at 14");
   AST_RTS_AT_56: assert property (auto_rts_o && depth64_o && rxf_count_i >= 7'h38 |=> rts_n_o)
      else $error("rts not dropped at 56");
   AST_RTS_STAYS: assert property (rts_n_o && !mcr_rts_set_i |=> rts_n_o)
      else $error("rts came back alone");
   AST_EXT_GATES: assert property (extend_disable_i |-> !depth64_o && !auto_rts_o)
      else $error("extend disable ignored");
   AST_AVAIL: assert property (rx_avail_irq_o == (rxf_count_i >= trigger_level_o))
      else $error("data available wrong");
   AST_CTS_HOLD: assert property (!bypass_o && auto_cts_o && cts_n_i |-> !txf_pop_o)
      else $error("transfer with cts high");
   AST_TX_POP: assert property (!bypass_o && txf_pop_o |=> tx_start_o && tx_data_o == $past(txf_data_i))
      else $error("pop without start");
   AST_BYP_READ: assert property (bypass_o && sub_rd_i && sub_addr_i == UFB_BYPASS_ADDR && txf_valid_i
      |-> txf_pop_o ##1 sub_rvalid_o && sub_rdata_o == $past(txf_data_i))
      else $error("bypass read wrong");
   cover property (auto_rts_o && depth64_o && rts_n_o);
   cover property (bypass_o && txf_pop_o);
   cover property (auto_cts_o && cts_n_i && txf_valid_i);
endmodule

bind ufb_ctrl ufb_ctrl_checker ufb_ctrl_checker_i (.*);

/* bench/ufb_far_model.sv */
// Far side of ufb_ctrl: serial transmitter and receive FIFO fill.
// Assumes one clock; drain_i removes one character a cycle.
`timescale 1ns/1ps
module ufb_far_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tx_start_i,
   input wire logic [3:0] char_len_i,
   input wire logic rxf_push_i,
   input wire logic drain_i,
   output logic tx_busy_o,
   output logic tx_char_done_o,
   output logic rxf_full_o,
   output logic [6:0] rxf_count_o
);
   // ====================================
   // Transmitter and fill counter
   logic [3:0] left;
   assign rxf_full_o = rxf_count_o == 7'h40;
   // Character length comes from the bench; every character the bench starts uses length 9.
   always @(posedge clk_i)
   begin
      tx_char_done_o <= 1'b0;
      if (rst_i)
      begin
         tx_busy_o <= 1'b0;
         left <= 4'h0;
         rxf_count_o <= 7'h00;
      end
      else
      begin
         rxf_count_o <= rxf_count_o + 7'(rxf_push_i && !rxf_full_o) - 7'(drain_i && rxf_count_o != 0);
         if (tx_start_i)
         begin
            tx_busy_o <= 1'b1;
            left <= char_len_i;
         end
         else if (tx_busy_o && left == 0)
         begin
            tx_busy_o <= 1'b0;
            tx_char_done_o <= 1'b1;
         end
         else if (left != 0)
            left <= left - 4'h1;
      end
   end
endmodule

/* bench/ufb_ctrl_test.sv */
// Self-checking bench for ufb_ctrl with the far-side model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
module ufb_ctrl_test;
   import ufb_pkg::*;
   logic clk_i = '0, rst_i = '1, extend_disable_i = '0, sub_wr_i = '0, sub_rd_i = '0, scr_wr_i = '0;
   logic fcr_wr_i = '0, mcr_rts_set_i = '0, mcr_rts_clr_i = '0, ser_rx_valid_i = '0, ser_rx_pe_i = '0;
   logic ser_rx_fe_i = '0, ser_rx_bi_i = '0, txf_valid_i = '0, cts_n_i = '0, drain = '0, e64;
   logic [8:0] sub_addr_i = '0;
   logic [7:0] sub_wdata_i = '0, scr_wdata_i = '0, fcr_wdata_i = '0, ser_rx_data_i = '0, txf_data_i = '0;
   logic [3:0] clen = 4'h2;
   logic [7:0] sub_rdata_o, rxf_data_o, tx_data_o;
   logic [6:0] trigger_level_o, rxf_count_i;
   logic [6:0] t64[4] = '{7'h01, 7'h10, 7'h20, 7'h38};
   logic [6:0] t16[4] = '{UFB_TRIG_16_0, UFB_TRIG_16_1, UFB_TRIG_16_2, UFB_TRIG_16_3};
   logic [2:0] rxf_err_o;
   logic sub_rvalid_o, bypass_o, auto_cts_o, auto_rts_o, depth64_o, ser_rx_ready_o, rxf_push_o;
   logic rx_avail_irq_o, rx_err_irq_o, txf_pop_o, tx_start_o, rts_n_o, rxf_full_i, tx_busy_i, tx_char_done_i;
   logic [10:0] rx_q[$];
   int failures = 0, check_count = 0, starts = 0, lvl;
   ufb_ctrl ufb_ctrl_i (.*);
   ufb_far_model ufb_far_model_i (.clk_i, .rst_i, .tx_start_i(tx_start_o), .char_len_i(clen),
      .rxf_push_i(rxf_push_o), .drain_i(drain), .tx_busy_o(tx_busy_i), .tx_char_done_o(tx_char_done_i),
      .rxf_full_o(rxf_full_i), .rxf_count_o(rxf_count_i));
   initial
   begin
      forever #20 clk_i = ~clk_i;
   end
   // ====================================
   // Tasks
   task chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task give_verdict;
      if (failures == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Kinds: 0 subsystem control, 1 FIFO control, 2 host RTS set.
   task ctl(input int k, input logic [7:0] d);
      @(posedge clk_i);
      scr_wdata_i <= d;
      fcr_wdata_i <= d;
      scr_wr_i <= k == 0;
      fcr_wr_i <= k == 1;
      mcr_rts_set_i <= k == 2;
      @(posedge clk_i);
      {scr_wr_i, fcr_wr_i, mcr_rts_set_i} <= 3'h0;
      #1;
   endtask
   task sub_acc(input logic rd, input logic [8:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sub_addr_i <= a;
      sub_wdata_i <= d;
      txf_data_i <= d;
      sub_rd_i <= rd;
      sub_wr_i <= !rd;
      @(posedge clk_i);
      {sub_rd_i, sub_wr_i} <= 2'h0;
      #1;
      if (rd)
         chk(sub_rvalid_o === 1'b1 && sub_rdata_o === d, "bypass read");
      else if (a == UFB_BYPASS_ADDR && bypass_o === 1'b1)
         rx_q.push_back({3'h0, d});
   endtask
   // A serial byte counts as taken at the edge where ready is seen high.
   task ser_rx(input logic [10:0] v);
      @(posedge clk_i);
      {ser_rx_bi_i, ser_rx_fe_i, ser_rx_pe_i, ser_rx_data_i} <= v;
      ser_rx_valid_i <= 1'b1;
      @(posedge clk_i);
      while (ser_rx_ready_o !== 1'b1)
         @(posedge clk_i);
      ser_rx_valid_i <= 1'b0;
      rx_q.push_back(v);
   endtask
   always @(posedge clk_i)
   begin
      if (!rst_i && rxf_push_o === 1'b1)
      begin
         chk(rx_q.size() > 0 && {rxf_err_o, rxf_data_o} === rx_q.pop_front(), "rx byte");
         chk(rx_err_irq_o === (rxf_err_o != 3'h0), "rx error irq");
      end
      if (!rst_i && tx_start_o === 1'b1)
      begin
         starts++;
         chk(tx_data_o === txf_data_i, "tx byte");
      end
   end
   // ====================================
   // Scenarios
   initial
   begin
      void'($urandom(32'hd675));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk(bypass_o === 1'b0 && rts_n_o === 1'b1, "reset state");
      for (int i = 0; i < 32; i++)
      begin
         extend_disable_i <= i[4];
         ctl(1, {i[1:0], i[3:2], 4'h0});
         e64 = i[3] && !i[4];
         chk(depth64_o === e64 && auto_rts_o === (i[2] && !i[4]), "fifo mode");
         chk(trigger_level_o === (e64 ? t64[i[1:0]] : t16[i[1:0]]), "trigger");
      end
      extend_disable_i <= 1'b0;
      ctl(0, 8'h80);
      txf_valid_i <= 1'b1;
      repeat (3) sub_acc(1, UFB_BYPASS_ADDR, 8'($urandom));
      txf_valid_i <= 1'b0;
      for (int m = 0; m < 2; m++)
      begin
         ctl(1, {2'h0, m[0], 1'b1, 4'h0});
         ctl(2, 8'h00);
         lvl = m ? 56 : 14;
         for (int n = 1; n <= lvl; n++)
         begin
            sub_acc(0, UFB_BYPASS_ADDR, 8'($urandom));
            repeat (5) @(posedge clk_i);
            #1;
            chk(rts_n_o === (n == lvl), "auto rts");
            chk(rx_avail_irq_o === 1'b1, "data available");
         end
         ctl(2, 8'h00);
         chk(rts_n_o === 1'b1, "auto clear beats set");
         @(posedge clk_i);
         drain <= 1'b1;
         repeat (lvl + 2) @(posedge clk_i);
         drain <= 1'b0;
         #1;
         chk(rts_n_o === 1'b1, "no self reassert");
         chk(rx_avail_irq_o === 1'b0, "drained below trigger");
         ctl(2, 8'h00);
         chk(rts_n_o === 1'b0, "host reassert");
      end
      ctl(0, 8'h00);
      repeat (4) ser_rx(11'($urandom));
      sub_acc(0, UFB_MCR_WR_ADDR, 8'h20);
      chk(auto_cts_o === 1'b1, "auto cts on");
      cts_n_i <= 1'b1;
      txf_valid_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      chk(starts === 0, "cts holds");
      clen <= 4'h9;
      cts_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      cts_n_i <= 1'b1;
      repeat (30) @(posedge clk_i);
      chk(starts === 1, "finish then stop");
      cts_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(starts === 2, "resume");
      give_verdict;
   end
   // The whole sequence needs about 750 cycles.
   initial
   begin
      repeat (20000) @(posedge clk_i);
      failures++;
      give_verdict;
   end
endmodule
